// ---- hw/ccr_channel_regs.sv ----
// channel one configuration register bank with digital volume stage
//
// Function
// - Setup bit 7 picks microphone input when 0 and line input when 1, reset 0.
// - Setup bits 6-5 pick differential (0) or single-ended (1) input, 2 and 3 reserved, reset 0.
// - Setup bit 4 picks AC coupling when 0 and DC coupling when 1, reset 1.
// - Setup bit 3 picks low swing when 0 and high swing when 1, reset 0.
// - Setup bits 2-1 pick high SNR (0) or high CMRR (2), 1 is not to be used and 3 reserved, reset 0.
// - Setup bit 0 enables automatic gain control as set by the external AGC mode bit, reset disabled.
// - Gain bits 7-2 give 0 to 42 dB in 1 dB steps, codes above 42 reserved, reset 0 dB.
// - Gain bit 1 is reserved read-write and bit 0 reserved read-only, both zero and written as zero.
// - Volume code 0 mutes the channel output.
// - Volume codes from 1 step by 0.5 dB, code 1 is -100 dB and code 201 unity.
// - Volume codes above 201 add gain in 0.5 dB steps up to 27 dB at code 255.
// - The volume field is bits 7-0 and resets to code 201, unity.
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps

module ccr_channel_regs
   import ccr_pkg::*;
(
   input  wire logic                       i_mclk,     // 40 MHz clock
   input  wire logic                       i_rst,      // async reset, active high
   input  wire logic [ccr_pkg::CCR_AW-1:0] i_addr,     // register address
   input  wire logic [ccr_pkg::CCR_DW-1:0] i_wdata,    // write data
   input  wire logic                       i_wr,       // write strobe
   input  wire logic                       i_rd,       // read strobe
   input  wire logic                       i_agc_mode, // AGC setting from the AGC config register
   input  wire ccr_pkg::ccr_sample_t       i_sample,   // sample from the decimator
   output logic      [ccr_pkg::CCR_DW-1:0] o_rdata_q,  // read data, cycle after i_rd
   output ccr_pkg::ccr_fe_cfg_t            o_fe_q,     // front end configuration
   output logic                            o_agc_run_q,// AGC active
   output logic                            o_muted_q,  // channel muted
   output ccr_pkg::ccr_sample_t            o_sample_q  // volume-scaled sample
);
   import ccr_pkg::*;

   logic [CCR_DW-1:0] setup_q;
   logic [CCR_DW-1:0] gain_q;
   logic [CCR_DW-1:0] vol_q;
   logic              wr_setup;
   logic              wr_gain;
   logic              wr_vol;

   // shared address decode for the three write enables
   function automatic logic ccr_hit(input logic              strobe,
                                    input logic [CCR_AW-1:0] addr,
                                    input logic [CCR_AW-1:0] ofs);
      return strobe && (addr == ofs);
   endfunction

   assign wr_setup = ccr_hit(i_wr, i_addr, CCR_OFS_SETUP);
   assign wr_gain  = ccr_hit(i_wr, i_addr, CCR_OFS_GAIN);
   assign wr_vol   = ccr_hit(i_wr, i_addr, CCR_OFS_VOL);

   // decode a setup/gain pair into the front end view
   function automatic ccr_fe_cfg_t ccr_decode(input logic [CCR_DW-1:0] s, input logic [CCR_DW-1:0] g);
      ccr_fe_cfg_t c;
      c.line_input     = s[CCR_B_INTYPE];
      c.source         = ccr_src_t'(s[CCR_B_SRC_HI:CCR_B_SRC_LO]);
      c.dc_coupled     = s[CCR_B_COUPLE];
      c.high_swing     = s[CCR_B_RANGE];
      c.perf           = ccr_perf_t'(s[CCR_B_PERF_HI:CCR_B_PERF_LO]);
      c.agc_enable     = s[CCR_B_AGC];
      c.analog_gain_db = g[CCR_B_GAIN_HI:CCR_B_GAIN_LO];
      c.source_ok      = (c.source == CCR_SRC_DIFF) || (c.source == CCR_SRC_SINGLE);
      c.perf_ok        = (c.perf == CCR_PERF_SNR) || (c.perf == CCR_PERF_CMRR);
      c.gain_ok        = (c.analog_gain_db <= CCR_GAIN_MAX);
      return c;
   endfunction

   // scale by 10^((code-201)/40); octaves are taken as exact 6 dB, so the
   // deepest codes drift by a few tenths of a dB, a trade for a 12 entry table
   function automatic logic signed [CCR_SW-1:0] ccr_apply_vol(input logic signed [CCR_SW-1:0] s,
                                                              input logic [CCR_DW-1:0]        code);
      logic [8:0]               y;
      logic [8:0]               q;
      logic [3:0]               r;
      logic [5:0]               sh;
      logic signed [CCR_PW-1:0] p;
      logic signed [CCR_PW-1:0] t;
      logic signed [CCR_SW-1:0] res;
      y   = {1'b0, code} + CCR_VOL_BIAS;
      q   = y / CCR_VOL_STEPS;
      r   = 4'(y % CCR_VOL_STEPS);
      sh  = CCR_SHIFT_BASE - 6'(q);
      p   = $signed({{(CCR_PW-CCR_SW){s[CCR_SW-1]}}, s}) * $signed({{(CCR_PW-CCR_MW){1'b0}}, CCR_MANT[r]});
      t   = p >>> sh;
      if (t > CCR_SAT_MAX) begin
         res = CCR_SAT_MAX[CCR_SW-1:0];
      end else if (t < CCR_SAT_MIN) begin
         res = CCR_SAT_MIN[CCR_SW-1:0];
      end else begin
         res = t[CCR_SW-1:0];
      end
      return res;
   endfunction

   // input setup register
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         setup_q <= CCR_RST_SETUP;
      end else if (wr_setup) begin
         setup_q <= i_wdata;
      end
   end

   // analog gain register; the read-only bit never stores a one
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         gain_q <= CCR_RST_GAIN;
      end else if (wr_gain) begin
         gain_q <= i_wdata & CCR_GAIN_WMASK;
      end
   end

   // digital volume register
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         vol_q <= CCR_RST_VOL;
      end else if (wr_vol) begin
         vol_q <= i_wdata;
      end
   end

   // read port; unmapped addresses and idle cycles read zero
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_rdata_q <= CCR_RST_GAIN;
      end else if (i_rd) begin
         unique case (i_addr)
            CCR_OFS_SETUP: begin
               o_rdata_q <= setup_q;
            end
            CCR_OFS_GAIN: begin
               o_rdata_q <= gain_q;
            end
            CCR_OFS_VOL: begin
               o_rdata_q <= vol_q;
            end
            default: begin
               o_rdata_q <= CCR_RST_GAIN;
            end
         endcase
      end else begin
         o_rdata_q <= CCR_RST_GAIN;
      end
   end

   // front end view lags a register write by one cycle
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_fe_q <= ccr_decode(CCR_RST_SETUP, CCR_RST_GAIN);
      end else begin
         o_fe_q <= ccr_decode(setup_q, gain_q);
      end
   end

   // agc only runs when enabled here and in the shared AGC setting;
   // AC coupling is left to software, no hardware interlock
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_agc_run_q <= 1'b0;
      end else begin
         o_agc_run_q <= setup_q[CCR_B_AGC] && i_agc_mode;
      end
   end

   // mute flag
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_muted_q <= 1'b0;
      end else begin
         o_muted_q <= (vol_q == CCR_VOL_MUTE);
      end
   end

   // volume stage, one cycle of latency
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_sample_q <= '0;
      end else begin
         o_sample_q.valid <= i_sample.valid;
         if (vol_q == CCR_VOL_MUTE) begin
            o_sample_q.data <= CCR_ZERO;
         end else begin
            o_sample_q.data <= ccr_apply_vol(i_sample.data, vol_q);
         end
      end
   end

   line_input_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      wr_setup |-> ##2 (o_fe_q.line_input == $past(i_wdata[CCR_B_INTYPE], 2)))
      else $error("input type does not follow the setup write");

   source_decode_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      wr_setup |-> ##2 (o_fe_q.source_ok == ($past(i_wdata[CCR_B_SRC_HI], 2) == 1'b0)))
      else $error("input source validity decoded wrongly");

   coupling_reset_a: assert property (@(posedge i_mclk)
      $fell(i_rst) |-> (o_fe_q.dc_coupled && setup_q[CCR_B_COUPLE] && !o_fe_q.line_input))
      else $error("coupling not DC after reset");

   swing_range_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      wr_setup ##1 !wr_setup |-> ##1 (o_fe_q.high_swing == $past(i_wdata[CCR_B_RANGE], 2)))
      else $error("swing range does not follow the setup write");

   perf_decode_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      (o_fe_q.perf_ok == ($past(setup_q[CCR_B_PERF_LO]) == 1'b0)))
      else $error("performance mode validity decoded wrongly");

   agc_enable_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      (!setup_q[CCR_B_AGC] || !i_agc_mode) |=> !o_agc_run_q)
      else $error("agc running while disabled");

   gain_readback_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      (wr_gain ##1 (i_rd && i_addr == CCR_OFS_GAIN)) |=> (o_rdata_q == ($past(i_wdata, 2) & CCR_GAIN_WMASK)))
      else $error("gain register read back wrong");

   gain_ro_bit_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      (i_rd && i_addr == CCR_OFS_GAIN) |=> !o_rdata_q[CCR_B_GAIN_RO])
      else $error("read-only gain bit reads one");

   mute_output_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      (vol_q == CCR_VOL_MUTE) |=> (o_muted_q && o_sample_q.data == CCR_ZERO))
      else $error("muted channel passes signal");

   unity_gain_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      (vol_q == CCR_VOL_UNITY) |=> (o_sample_q.data == $past(i_sample.data)))
      else $error("unity volume alters the sample");

   top_gain_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      (vol_q == CCR_VOL_TOP && i_sample.data == 24'sh000400) |=> (o_sample_q.data == 24'sh005A67))
      else $error("top volume code gain wrong");

   volume_reset_a: assert property (@(posedge i_mclk)
      $fell(i_rst) |-> (vol_q == CCR_RST_VOL && !o_muted_q))
      else $error("volume not unity after reset");

   saturate_sign_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      (vol_q != CCR_VOL_MUTE && i_sample.data[CCR_SW-1] == 1'b0) |=> !o_sample_q.data[CCR_SW-1])
      else $error("positive sample wrapped negative");

   source_follow_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      wr_setup
      |-> ##2 (o_fe_q.source == ccr_src_t'($past(i_wdata[CCR_B_SRC_HI:CCR_B_SRC_LO], 2))))
      else $error("input source does not follow the setup write");

   coupling_follow_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      wr_setup
      |-> ##2 (o_fe_q.dc_coupled == $past(i_wdata[CCR_B_COUPLE], 2)))
      else $error("coupling does not follow the setup write");

   perf_follow_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      wr_setup
      |-> ##2 (o_fe_q.perf == ccr_perf_t'($past(i_wdata[CCR_B_PERF_HI:CCR_B_PERF_LO], 2))))
      else $error("performance mode does not follow the setup write");

   agc_bit_follow_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      wr_setup
      |-> ##2 (o_fe_q.agc_enable == $past(i_wdata[CCR_B_AGC], 2)))
      else $error("agc enable does not follow the setup write");

   agc_run_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      (setup_q[CCR_B_AGC] && i_agc_mode)
      |=> o_agc_run_q)
      else $error("agc idle while enabled");

   gain_follow_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      wr_gain
      |-> ##2 (o_fe_q.analog_gain_db == $past(i_wdata[CCR_B_GAIN_HI:CCR_B_GAIN_LO], 2)))
      else $error("analog gain does not follow the gain write");

   gain_range_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      wr_gain
      |-> ##2 (o_fe_q.gain_ok == ($past(i_wdata[CCR_B_GAIN_HI:CCR_B_GAIN_LO], 2) <= CCR_GAIN_MAX)))
      else $error("reserved gain code flagged wrongly");

   gain_ro_store_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      wr_gain
      |=> !gain_q[CCR_B_GAIN_RO])
      else $error("read-only gain bit stored a one");

   intype_reset_a: assert property (@(posedge i_mclk)
      $fell(i_rst)
      |-> (!setup_q[CCR_B_INTYPE] && !o_fe_q.line_input))
      else $error("input type not microphone after reset");

   source_reset_a: assert property (@(posedge i_mclk)
      $fell(i_rst)
      |-> (o_fe_q.source == CCR_SRC_DIFF && o_fe_q.source_ok))
      else $error("input source not differential after reset");

   swing_reset_a: assert property (@(posedge i_mclk)
      $fell(i_rst)
      |-> (!setup_q[CCR_B_RANGE] && !o_fe_q.high_swing))
      else $error("swing range not low after reset");

   perf_reset_a: assert property (@(posedge i_mclk)
      $fell(i_rst)
      |-> (o_fe_q.perf == CCR_PERF_SNR && o_fe_q.perf_ok))
      else $error("performance mode not high SNR after reset");

   agc_reset_a: assert property (@(posedge i_mclk)
      $fell(i_rst)
      |-> (!setup_q[CCR_B_AGC] && !o_agc_run_q))
      else $error("agc not disabled after reset");

   gain_reset_a: assert property (@(posedge i_mclk)
      $fell(i_rst)
      |-> (gain_q == CCR_RST_GAIN && o_fe_q.analog_gain_db == CCR_RST_GAIN[CCR_B_GAIN_HI:CCR_B_GAIN_LO]))
      else $error("analog gain not 0 dB after reset");

   setup_readback_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      (wr_setup ##1 (i_rd && i_addr == CCR_OFS_SETUP))
      |=> (o_rdata_q == $past(i_wdata, 2)))
      else $error("setup register read back wrong");

   volume_readback_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      (wr_vol ##1 (i_rd && i_addr == CCR_OFS_VOL))
      |=> (o_rdata_q == $past(i_wdata, 2)))
      else $error("volume register read back wrong");

   mute_clear_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      (vol_q != CCR_VOL_MUTE)
      |=> !o_muted_q)
      else $error("channel flagged muted at a nonzero code");

   mute_valid_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      (vol_q == CCR_VOL_MUTE)
      |=> (o_sample_q.valid == $past(i_sample.valid)))
      else $error("muted channel drops the sample strobe");

   saturate_high_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      (vol_q == CCR_VOL_TOP && i_sample.data == CCR_SAT_MAX[CCR_SW-1:0])
      |=> (o_sample_q.data == CCR_SAT_MAX[CCR_SW-1:0]))
      else $error("positive full scale not clipped");

   saturate_low_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      (vol_q == CCR_VOL_TOP && i_sample.data == CCR_SAT_MIN[CCR_SW-1:0])
      |=> (o_sample_q.data == CCR_SAT_MIN[CCR_SW-1:0]))
      else $error("negative full scale not clipped");

   negative_sign_a: assert property (@(posedge i_mclk) disable iff (i_rst)
      (vol_q != CCR_VOL_MUTE && i_sample.data[CCR_SW-1])
      |=> o_sample_q.data[CCR_SW-1])
      else $error("negative sample wrapped positive");

endmodule

// ---- hw/ccr_pkg.sv ----
// constants, types and gain table for the channel one configuration register bank
package ccr_pkg;

   localparam int CCR_AW = 8;
   localparam int CCR_DW = 8;
   localparam int CCR_SW = 24;
   localparam int CCR_MW = 16;
   localparam int CCR_PW = 41;

   // register byte addresses
   localparam logic [CCR_AW-1:0] CCR_OFS_SETUP = 8'h3C;
   localparam logic [CCR_AW-1:0] CCR_OFS_GAIN  = 8'h3D;
   localparam logic [CCR_AW-1:0] CCR_OFS_VOL   = 8'h3E;

   // reset values
   localparam logic [CCR_DW-1:0] CCR_RST_SETUP = 8'h10;
   localparam logic [CCR_DW-1:0] CCR_RST_GAIN  = 8'h00;
   localparam logic [CCR_DW-1:0] CCR_RST_VOL   = 8'hC9;

   // input setup field positions
   localparam int CCR_B_INTYPE  = 7;
   localparam int CCR_B_SRC_HI  = 6;
   localparam int CCR_B_SRC_LO  = 5;
   localparam int CCR_B_COUPLE  = 4;
   localparam int CCR_B_RANGE   = 3;
   localparam int CCR_B_PERF_HI = 2;
   localparam int CCR_B_PERF_LO = 1;
   localparam int CCR_B_AGC     = 0;

   // analog gain field positions; bit 0 is read-only zero
   localparam int                CCR_B_GAIN_HI = 7;
   localparam int                CCR_B_GAIN_LO = 2;
   localparam int                CCR_B_GAIN_RO = 0;
   localparam logic [CCR_DW-1:0] CCR_GAIN_WMASK = 8'hFE;
   localparam logic [5:0]        CCR_GAIN_MAX   = 6'h2A;

   // digital volume codes
   localparam logic [CCR_DW-1:0] CCR_VOL_MUTE  = 8'h00;
   localparam logic [CCR_DW-1:0] CCR_VOL_UNITY = 8'hC9;
   localparam logic [CCR_DW-1:0] CCR_VOL_TOP   = 8'hFF;

   // volume arithmetic: code+bias split into 6 dB octaves of 12 half-dB steps
   localparam logic [8:0] CCR_VOL_BIAS   = 9'h00F;
   localparam logic [8:0] CCR_VOL_STEPS  = 9'h00C;
   localparam logic [5:0] CCR_SHIFT_BASE = 6'h20;

   // 10^(r/40) for r = 0..11, one is 16'h4000
   localparam logic [CCR_MW-1:0] CCR_MANT [12] = '{
      16'h4000, 16'h43CB, 16'h47CF, 16'h4C10, 16'h5092, 16'h5558,
      16'h5A67, 16'h5FC2, 16'h656F, 16'h6B71, 16'h71CF, 16'h788E};

   localparam logic signed [CCR_PW-1:0] CCR_SAT_MAX = 41'sh000007FFFFF;
   localparam logic signed [CCR_PW-1:0] CCR_SAT_MIN = 41'sh1FFFF800000;
   localparam logic [CCR_SW-1:0]        CCR_ZERO    = 24'h000000;

   typedef enum logic [1:0] {
      CCR_SRC_DIFF,
      CCR_SRC_SINGLE,
      CCR_SRC_RSV2,
      CCR_SRC_RSV3
   } ccr_src_t;

   typedef enum logic [1:0] {
      CCR_PERF_SNR,
      CCR_PERF_NOUSE,
      CCR_PERF_CMRR,
      CCR_PERF_RSV3
   } ccr_perf_t;

   typedef struct packed {
      logic       line_input;
      ccr_src_t   source;
      logic       dc_coupled;
      logic       high_swing;
      ccr_perf_t  perf;
      logic       agc_enable;
      logic [5:0] analog_gain_db;
      logic       source_ok;
      logic       perf_ok;
      logic       gain_ok;
   } ccr_fe_cfg_t;

   typedef struct packed {
      logic                     valid;
      logic signed [CCR_SW-1:0] data;
   } ccr_sample_t;

endpackage

// ---- verif/tb_channel_one_config_regs.sv ----
// self-checking bench for the channel one configuration register bank
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
   $display("[FAIL] %0t mismatch got %h exp %h", $time, (g), (e)); end end

module tb_channel_one_config_regs;
   import ccr_pkg::*;
   logic               i_mclk;
   logic               i_rst;
   logic               i_wr;
   logic               i_rd;
   logic               i_agc_mode;
   logic [CCR_AW-1:0]  i_addr;
   logic [CCR_DW-1:0]  i_wdata;
   ccr_sample_t        i_sample;
   logic [CCR_DW-1:0]  o_rdata_q;
   ccr_fe_cfg_t        o_fe_q;
   logic               o_agc_run_q;
   logic               o_muted_q;
   ccr_sample_t        o_sample_q;
   int                 n_fail;
   int                 total_checks;
   logic [31:0]        rng;
   logic [7:0]         s;
   logic [7:0]         g;
   logic [7:0]         v;
   logic [7:0]         rv;
   logic [7:0]         gain_corner [4] = '{8'hA8, 8'hAC, 8'hFF, 8'h03};
   logic [7:0]         vol_corner [7]  = '{8'h00, 8'h01, 8'h02, 8'hC9, 8'hCA, 8'hFE, 8'hFF};
   logic [7:0]         rst_addr [3]    = '{8'h3C, 8'h3D, 8'h3E};
   logic [7:0]         rst_val [3]     = '{8'h10, 8'h00, 8'hC9};

   ccr_channel_regs DUT (
      .i_mclk      (i_mclk),
      .i_rst       (i_rst),
      .i_addr      (i_addr),
      .i_wdata     (i_wdata),
      .i_wr        (i_wr),
      .i_rd        (i_rd),
      .i_agc_mode  (i_agc_mode),
      .i_sample    (i_sample),
      .o_rdata_q   (o_rdata_q),
      .o_fe_q      (o_fe_q),
      .o_agc_run_q (o_agc_run_q),
      .o_muted_q   (o_muted_q),
      .o_sample_q  (o_sample_q)
   );

   function automatic logic [31:0] nxt();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction

   // decoded front end view: setup byte as is, gain code, then the three reserved-code flags
   function automatic logic [16:0] fe(input logic [7:0] st, input logic [7:0] gn);
      return {st, gn[7:2], ~st[6], ~st[1], gn[7:2] <= 6'h2A};
   endfunction

   // six-dB octave scaling as promised by the designer, not ideal decibels
   function automatic logic [23:0] scale(input logic [7:0] c, input logic signed [23:0] x);
      int                 y;
      logic signed [40:0] p;
      y = int'(c) + 15;
      p = (x * $signed({25'h0, CCR_MANT[y % 12]})) >>> (32 - y / 12);
      if (c == 8'h00) return 24'h000000;
      if (p > 41'sh7FFFFF) return 24'h7FFFFF;
      if (p < -41'sh800000) return 24'h800000;
      return p[23:0];
   endfunction

   task automatic give_verdict();
      $display("checks %0d failures %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic tick();
      @(posedge i_mclk);
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] dd);
      @(posedge i_mclk);
      i_wr    <= 1'b1;
      i_addr  <= a;
      i_wdata <= dd;
      @(posedge i_mclk);
      i_wr    <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] dd);
      @(posedge i_mclk);
      i_rd   <= 1'b1;
      i_addr <= a;
      @(posedge i_mclk);
      i_rd   <= 1'b0;
      #1;
      dd = o_rdata_q;
   endtask

   // write then read back in the very next cycle, strobes with no gap
   task automatic wrrd(input logic [7:0] a, input logic [7:0] dd, output logic [7:0] q);
      @(posedge i_mclk);
      i_wr    <= 1'b1;
      i_addr  <= a;
      i_wdata <= dd;
      @(posedge i_mclk);
      i_wr    <= 1'b0;
      i_rd    <= 1'b1;
      @(posedge i_mclk);
      i_rd    <= 1'b0;
      #1;
      q = o_rdata_q;
   endtask

   task automatic smp(input logic signed [23:0] dd);
      @(posedge i_mclk);
      i_sample <= '{valid: 1'b1, data: dd};
      @(posedge i_mclk);
      i_sample <= '{valid: 1'b0, data: 24'h000000};
      #1;
      `CHK(o_sample_q, {1'b1, scale(v, dd)})
   endtask

   // reset values straight after a release, then the unity volume path
   task automatic chk_reset();
      `CHK(o_fe_q, fe(8'h10, 8'h00))
      `CHK({o_agc_run_q, o_muted_q, o_rdata_q}, 10'h000)
      for (int i = 0; i < 3; i++) begin
         rd(rst_addr[i], rv);
         `CHK(rv, rst_val[i])
      end
      smp(24'h123456);
   endtask

   initial begin
      i_mclk = 1'b0;
      forever #12.5 i_mclk = ~i_mclk;
   end

   // the whole sequence needs well under 5000 cycles
   initial begin
      #(25 * 20000);
      n_fail++;
      give_verdict();
   end

   initial begin
      i_rst = 1'b1;
      i_wr = 1'b0;
      i_rd = 1'b0;
      i_agc_mode = 1'b0;
      i_addr = 8'h00;
      i_wdata = 8'h00;
      i_sample = '{valid: 1'b0, data: 24'h000000};
      n_fail = 0;
      total_checks = 0;
      rng = 32'h7510;
      v = 8'hC9;
      repeat (5) @(posedge i_mclk);
      i_rst <= 1'b0;
      #1;
      chk_reset();
      // unmapped places ignore writes and read zero
      wr(8'h3F, 8'hA5);
      rd(8'h3F, rv);
      `CHK(rv, 8'h00)
      rd(8'h3C, rv);
      `CHK(rv, 8'h10)
      tick();
      `CHK(o_rdata_q, 8'h00)
      for (int i = 0; i < 40; i++) begin
         s = 8'(nxt());
         if (s[4]) s[0] = 1'b0;
         g = (i < 4) ? gain_corner[i] : 8'(nxt());
         @(posedge i_mclk);
         i_agc_mode <= rng[9];
         wrrd(CCR_OFS_SETUP, s, rv);
         `CHK(rv, s)
         wrrd(CCR_OFS_GAIN, g, rv);
         `CHK(rv, g & 8'hFE)
         tick();
         `CHK(o_fe_q, fe(s, g))
         `CHK(o_agc_run_q, s[0] & i_agc_mode)
         rd(CCR_OFS_SETUP, rv);
         `CHK(rv, s)
         rd(CCR_OFS_GAIN, rv);
         `CHK(rv, g & 8'hFE)
      end
      // a mid-run reset must bring back every reset value over random setup and gain contents
      @(posedge i_mclk);
      i_rst <= 1'b1;
      repeat (2) @(posedge i_mclk);
      i_rst <= 1'b0;
      #1;
      chk_reset();
      for (int i = 0; i < 27; i++) begin
         v = (i < 7) ? vol_corner[i] : 8'(nxt());
         wrrd(CCR_OFS_VOL, v, rv);
         `CHK(rv, v)
         rd(CCR_OFS_VOL, rv);
         `CHK(rv, v)
         `CHK(o_muted_q, v == 8'h00)
         smp(24'(nxt()));
         smp(24'h000400);
         smp(24'h7FFFFF);
         smp(24'h800000);
      end
      give_verdict();
   end
endmodule
